// *** rtl/qwc_coalescer.sv ***
// Memory request path from compute-unit lanes to the memory controller.
// Assumes one clock; downstream accepts one beat per valid&ready.
`include "qwc_params.svh"
module qwc_coalescer #(
  parameter int LANES = `QWC_QUARTER_LANES,
  parameter int ADDR_W = `QWC_ADDR_W,
  parameter int ELEM_W = `QWC_ELEM_W,
  parameter int FIFO_DEPTH = `QWC_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire qwc_pkg::qwc_op_e req_op,
  input wire qwc_pkg::qwc_path_e req_path,
  input wire qwc_pkg::qwc_mem_e req_mem,
  input wire logic [LANES-1:0] req_active,
  input wire logic [LANES*ADDR_W-1:0] req_addr,
  input wire logic [LANES*ELEM_W-1:0] req_data,
  output logic mc_valid,
  input wire logic mc_ready,
  output logic mc_coalesced,
  output logic mc_is_read,
  output logic [LANES-1:0] mc_lane_mask,
  output logic [ADDR_W-1:0] mc_addr,
  output logic [LANES*ELEM_W-1:0] mc_data
);
  localparam int LW = $clog2(LANES);
  localparam int BW = 1 + 1 + LANES + ADDR_W + LANES * ELEM_W;
  initial begin
    if (LANES * 4 != `QWC_WAVE_LANES) $error("LANES must be a quarter of a wavefront");
    if (ADDR_W != `QWC_ADDR_W) $error("ADDR_W must be 32");
    if (ELEM_W != `QWC_ELEM_W) $error("ELEM_W must be 128");
  end

  // Stride check: every active lane at base + lane*4, base from lowest active lane
  function automatic logic stride_ok(input logic [LANES-1:0] act,
                                     input logic [LANES*ADDR_W-1:0] addr);
    logic ok;
    logic found;
    logic [ADDR_W-1:0] base;
    ok = 1'b1;
    found = 1'b0;
    base = '0;
    for (int i = 0; i < LANES; i++) begin
      if (act[i] && !found) begin
        found = 1'b1;
        base = addr[i*ADDR_W +: ADDR_W] - ADDR_W'(i * `QWC_WORD_BYTES);
      end
    end
    for (int i = 0; i < LANES; i++) begin
      if (act[i] && addr[i*ADDR_W +: ADDR_W] != base + ADDR_W'(i * `QWC_WORD_BYTES)) begin
        ok = 1'b0;
      end
    end
    return ok && found;
  endfunction

  // Lane index, used both to pick the next read or write lane and to find the base lane
  function automatic logic [LW-1:0] first_set(input logic [LANES-1:0] v);
    logic [LW-1:0] r;
    r = '0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (v[i]) r = LW'(i);
    end
    return r;
  endfunction

  typedef enum {
    ST_IDLE,
    ST_PROC,
    ST_SEND,
    ST_RD
  } qwc_st_e;

  qwc_st_e st_q;
  logic [1:0] pcnt_q;
  logic coal_q;
  logic rd_q;
  logic [LANES-1:0] act_q;
  logic [LANES-1:0] left_q;
  logic [LANES*ADDR_W-1:0] addr_q;
  logic [LANES*ELEM_W-1:0] data_q;
  logic take;
  logic can_coal;
  logic f_valid;
  logic f_ready;
  logic [BW-1:0] f_in;
  logic [BW-1:0] f_out;
  logic [LW-1:0] lane_sel;
  logic [ADDR_W-1:0] rd_addr;
  logic [LANES-1:0] same_mask;
  logic collide;
  logic collide_q;

  assign req_ready = (st_q == ST_IDLE);
  assign take = req_valid && req_ready;
  assign can_coal = (req_op == qwc_pkg::QWC_OP_WRITE) &&
                    (req_path == qwc_pkg::QWC_PATH_CACHELESS_DIRECT) &&
                    stride_ok(req_active, req_addr);
  assign collide = (req_mem == qwc_pkg::QWC_MEM_READ_WRITE_VIEW);

  // Capture one quarter group
  always_ff @(posedge ref_clk) begin
    if (take) begin
      act_q <= req_active;
      addr_q <= req_addr;
      data_q <= req_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      pcnt_q <= '0;
      coal_q <= 1'b0;
      rd_q <= 1'b0;
      left_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (take) begin
            coal_q <= can_coal;
            rd_q <= (req_op == qwc_pkg::QWC_OP_READ);
            left_q <= req_active;
            pcnt_q <= can_coal ? 2'(`QWC_COAL_CYCLES) : 2'(`QWC_UNCOAL_CYCLES);
            st_q <= ST_PROC;
          end
        end
        ST_PROC: begin
          // Colliding reads and uncoalesced writes leave one beat at a time
          if (pcnt_q == 2'h1) begin
            st_q <= ((rd_q && collide_q) || (!rd_q && !coal_q)) ? ST_RD : ST_SEND;
          end
          else pcnt_q <= pcnt_q - 2'h1;
        end
        ST_SEND: begin
          if (f_ready) st_q <= ST_IDLE;
        end
        ST_RD: begin
          if (f_ready) begin
            left_q <= left_q & ~same_mask;
            if ((left_q & ~same_mask) == '0) st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) collide_q <= 1'b0;
    else if (take) collide_q <= collide;
  end

  // Serial beats: a read groups lanes sharing one address, a write sends one lane
  assign lane_sel = first_set(left_q);
  assign rd_addr = addr_q[lane_sel*ADDR_W +: ADDR_W];
  always_comb begin
    same_mask = '0;
    for (int i = 0; i < LANES; i++) begin
      if (rd_q) begin
        same_mask[i] = left_q[i] && (addr_q[i*ADDR_W +: ADDR_W] == rd_addr);
      end else begin
        same_mask[i] = left_q[i] && (LW'(i) == lane_sel);
      end
    end
  end

  assign f_valid = (st_q == ST_SEND) || (st_q == ST_RD);
  always_comb begin
    if (st_q == ST_RD) begin
      // Own address of the lane or lanes in the mask
      f_in = {1'b0, rd_q, same_mask, rd_addr, data_q};
    end else if (coal_q) begin
      // One address, sixteen elements
      f_in = {1'b1, rd_q, act_q, addr_q[first_set(act_q)*ADDR_W +: ADDR_W] -
              ADDR_W'(first_set(act_q) * `QWC_WORD_BYTES), data_q};
    end else begin
      // Read-only read: whole group in one beat
      f_in = {1'b0, rd_q, act_q, addr_q[ADDR_W-1:0], data_q};
    end
  end

  qwc_fifo #(
    .WIDTH(BW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_in),
    .out_valid(mc_valid),
    .out_ready(mc_ready),
    .out_data(f_out)
  );

  assign mc_coalesced = f_out[BW-1];
  assign mc_is_read = f_out[BW-2];
  assign mc_lane_mask = f_out[BW-3 -: LANES];
  assign mc_addr = f_out[LANES*ELEM_W +: ADDR_W];
  assign mc_data = f_out[LANES*ELEM_W-1:0];

  AST_COAL_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (rst)
    take && can_coal |=> st_q == ST_PROC ##1 st_q != ST_PROC)
    else $error("coalesced group not processed in one cycle");
  AST_UNCOAL_TWO_CYCLES: assert property (@(posedge ref_clk) disable iff (rst)
    take && !can_coal |=> st_q == ST_PROC [*2] ##1 st_q != ST_PROC)
    else $error("uncoalesced group not processed in two cycles");
  AST_ATOMIC_NO_MERGE: assert property (@(posedge ref_clk) disable iff (rst)
    take && req_path == qwc_pkg::QWC_PATH_ATOMIC_CAPABLE |=> !coal_q)
    else $error("atomic capable path write merged");
  AST_READ_NO_MERGE: assert property (@(posedge ref_clk) disable iff (rst)
    take && req_op == qwc_pkg::QWC_OP_READ |=> !coal_q)
    else $error("read marked coalesced");
  AST_ONE_QUARTER: assert property (@(posedge ref_clk) disable iff (rst)
    take |=> !req_ready)
    else $error("second group taken while one in flight");
  AST_RD_SERIAL: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == ST_RD && f_ready |=> (left_q & $past(same_mask)) == '0)
    else $error("served read lanes not retired");
  AST_RO_NO_SERIAL: assert property (@(posedge ref_clk) disable iff (rst)
    take && req_op == qwc_pkg::QWC_OP_READ && !collide |=> ##[1:2] st_q == ST_SEND)
    else $error("read-only read serialised");
  AST_STRIDE_REQ: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == ST_SEND && coal_q |-> stride_ok(act_q, addr_q))
    else $error("merged group without base plus four stride");
  AST_WR_ONE_LANE: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == ST_RD && !rd_q |-> $onehot0(same_mask))
    else $error("uncoalesced write beat carries more than one lane");
  AST_WR_SERIAL: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == ST_PROC && pcnt_q == 2'h1 && !rd_q && !coal_q |=> st_q == ST_RD)
    else $error("uncoalesced write not sent lane by lane");
  AST_MC_STANDS: assert property (@(posedge ref_clk) disable iff (rst)
    mc_valid && !mc_ready |=> mc_valid && $stable(mc_addr) && $stable(mc_lane_mask))
    else $error("beat changed before the memory controller took it");
  AST_RD_NOT_COAL_OUT: assert property (@(posedge ref_clk) disable iff (rst)
    mc_valid && mc_is_read |-> !mc_coalesced)
    else $error("read beat flagged coalesced");
  COV_COAL: cover property (@(posedge ref_clk) take && can_coal);
  COV_UNCOAL: cover property (@(posedge ref_clk)
    take && !can_coal && req_op == qwc_pkg::QWC_OP_WRITE);
  COV_RD_SER: cover property (@(posedge ref_clk) st_q == ST_RD ##1 st_q == ST_RD);
  COV_RO_READ: cover property (@(posedge ref_clk)
    take && req_op == qwc_pkg::QWC_OP_READ && !collide);
  COV_FIFO_FULL: cover property (@(posedge ref_clk) f_valid && !f_ready);
endmodule

// *** include/qwc_params.svh ***
// Constants of the quarter-wave write coalescer.
// Assumes inclusion by bare name from the include folder.
`ifndef QWC_PARAMS_SVH
`define QWC_PARAMS_SVH
`define QWC_WAVE_LANES 64
`define QWC_QUARTER_LANES 16
`define QWC_ADDR_W 32
`define QWC_ELEM_W 128
`define QWC_WORD_BYTES 4
`define QWC_FIFO_DEPTH 8
`define QWC_UNCOAL_CYCLES 2
`define QWC_COAL_CYCLES 1
`endif

// *** include/qwc_pkg.sv ***
// Types of the quarter-wave write coalescer.
// Assumes qwc_params.svh on the include path.
`include "qwc_params.svh"
package qwc_pkg;
  typedef enum logic [1:0] {
    QWC_OP_WRITE,
    QWC_OP_READ
  } qwc_op_e;
  typedef enum logic {
    QWC_PATH_CACHELESS_DIRECT,
    QWC_PATH_ATOMIC_CAPABLE
  } qwc_path_e;
  typedef enum logic [1:0] {
    QWC_MEM_READ_WRITE_VIEW,
    QWC_MEM_READ_ONLY_VIEW,
    QWC_MEM_CONSTANT,
    QWC_MEM_TEXTURE
  } qwc_mem_e;
endpackage

// *** rtl/qwc_fifo.sv ***
// Small synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module qwc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// *** sim/qwc_mc_model.sv ***
// Memory controller stand-in: pops beats and logs them in order.
// Assumes the block holds mc_* steady until a beat is popped.
module qwc_mc_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic slow,
  input wire logic mc_valid,
  output logic mc_ready,
  input wire logic mc_coalesced,
  input wire logic mc_is_read,
  input wire logic [15:0] mc_lane_mask,
  input wire logic [31:0] mc_addr,
  input wire logic [2047:0] mc_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [177:0] log_q[$];
  logic tick_q;
  always_ff @(posedge ref_clk) begin
    tick_q <= rst ? 1'b0 : !tick_q;
    if (!rst && mc_valid && mc_ready)
      log_q.push_back({mc_coalesced, mc_is_read, mc_lane_mask, mc_addr, mc_data[3*128+:128]});
  end
  // Slow mode accepts every other cycle
  assign mc_ready = !rst && !hold && (!slow || tick_q);
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the write coalescer.
// Assumes qwc_pkg compiled first and the controller model beside it.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, req_valid = 0, hold = 0, slow = 0;
  logic req_ready, mc_valid, mc_ready, mc_coalesced, mc_is_read;
  qwc_pkg::qwc_op_e req_op = qwc_pkg::QWC_OP_WRITE;
  qwc_pkg::qwc_path_e req_path = qwc_pkg::QWC_PATH_CACHELESS_DIRECT;
  qwc_pkg::qwc_mem_e req_mem = qwc_pkg::QWC_MEM_READ_WRITE_VIEW;
  logic [15:0] req_active = 16'h0, mc_lane_mask;
  logic [511:0] req_addr = '0;
  logic [2047:0] req_data = '0, mc_data;
  logic [31:0] mc_addr;
  logic [177:0] e;
  int fails = 0, compares = 0, cyc = 0, lat;
  always #20 ref_clk = !ref_clk;
  qwc_coalescer u_dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_path(req_path), .req_mem(req_mem),
    .req_active(req_active), .req_addr(req_addr), .req_data(req_data),
    .mc_valid(mc_valid), .mc_ready(mc_ready), .mc_coalesced(mc_coalesced),
    .mc_is_read(mc_is_read), .mc_lane_mask(mc_lane_mask), .mc_addr(mc_addr),
    .mc_data(mc_data));
  qwc_mc_model u_mc (.ref_clk(ref_clk), .rst(rst), .hold(hold), .slow(slow),
    .mc_valid(mc_valid), .mc_ready(mc_ready), .mc_coalesced(mc_coalesced),
    .mc_is_read(mc_is_read), .mc_lane_mask(mc_lane_mask), .mc_addr(mc_addr),
    .mc_data(mc_data));
  task automatic give_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [177:0] got, input logic [177:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Mode 0 ascending, 1 mirrored odd lanes, 3 even lanes at b, odd at b+0x100
  // Inactive lanes get junk
  task automatic issue(input qwc_pkg::qwc_op_e op, input qwc_pkg::qwc_path_e p,
      input qwc_pkg::qwc_mem_e m, input logic [15:0] act, input int mode, input logic [31:0] b);
    @(posedge ref_clk);
    for (int i = 0; i < 16; i++) begin
      req_addr[i*32+:32] <= !act[i] ? 32'hdead_0000 :
          mode == 3 ? (i % 2 == 0 ? b : b + 32'h100) :
          (mode == 0 || i % 2 == 0) ? b + 32'(4 * i) : b + 32'(4 * (63 - i));
      req_data[i*128+:128] <= {96'h0, b + 32'(i)};
    end
    req_op <= op;
    req_path <= p;
    req_mem <= m;
    req_active <= act;
    req_valid <= 1'b1;
    lat = 0;
    do begin @(negedge ref_clk); lat++; end while (req_ready !== 1'b1 && lat < 100);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    lat = 0;
    do begin @(negedge ref_clk); lat++; end while (mc_valid !== 1'b1 && lat < 50);
  endtask
  task automatic t_write(input qwc_pkg::qwc_path_e p, input int mode, input logic c);
    logic [31:0] a;
    issue(qwc_pkg::QWC_OP_WRITE, p, qwc_pkg::QWC_MEM_READ_WRITE_VIEW, 16'hfffe, mode, 32'h1000);
    chk(178'(lat), c ? 178'd3 : 178'd4);
    repeat (20) @(posedge ref_clk);
    chk(178'(u_mc.log_q.size()), c ? 178'd1 : 178'd15);
    if (c) begin
      e = u_mc.log_q.pop_front();
      chk(e, {1'b1, 1'b0, 16'hfffe, 32'h1000, 96'h0, 32'h1003});
    end else begin
      // One beat per active lane, lowest lane first, each with its own address
      for (int i = 1; i < 16; i++) begin
        a = (mode == 0 || i % 2 == 0) ? 32'h1000 + 32'(4 * i) : 32'h1000 + 32'(4 * (63 - i));
        e = u_mc.log_q.pop_front();
        chk(e, {1'b0, 1'b0, 16'(1 << i), a, 96'h0, 32'h1003});
      end
    end
  endtask
  task automatic t_reads();
    slow <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      issue(qwc_pkg::QWC_OP_READ, qwc_pkg::QWC_PATH_CACHELESS_DIRECT, qwc_pkg::qwc_mem_e'(m),
          16'hffff, 3, 32'h2000);
      repeat (12) @(posedge ref_clk);
      chk(178'(u_mc.log_q.size()), m == 0 ? 178'd2 : 178'd1);
      e = u_mc.log_q.pop_front();
      chk(178'(e[176:128]), m == 0 ? {1'b1, 16'h5555, 32'h2000} :
          {1'b1, 16'hffff, 32'h2000});
      if (m == 0) begin
        e = u_mc.log_q.pop_front();
        chk(178'(e[176:128]), {1'b1, 16'haaaa, 32'h2100});
      end
    end
    slow <= 1'b0;
  endtask
  task automatic t_fill();
    hold <= 1'b1;
    for (int i = 0; i < 9; i++)
      issue(qwc_pkg::QWC_OP_WRITE, qwc_pkg::QWC_PATH_CACHELESS_DIRECT,
          qwc_pkg::QWC_MEM_READ_WRITE_VIEW, 16'hffff, 0, 32'(i * 'h100));
    repeat (10) @(negedge ref_clk);
    chk(178'(req_ready), 178'd0);
    @(posedge ref_clk);
    hold <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk(178'(u_mc.log_q.size()), 178'd9);
    for (int i = 0; i < 9; i++) begin
      e = u_mc.log_q.pop_front();
      chk(178'(e[177:128]), {1'b1, 1'b0, 16'hffff, 32'(i * 'h100)});
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_write(qwc_pkg::QWC_PATH_CACHELESS_DIRECT, 0, 1'b1);
    t_write(qwc_pkg::QWC_PATH_CACHELESS_DIRECT, 1, 1'b0);
    t_write(qwc_pkg::QWC_PATH_ATOMIC_CAPABLE, 0, 1'b0);
    t_reads();
    t_fill();
    give_verdict();
  end
endmodule
